// ### inc/tcw_pkg.sv
// Shared constants, carrier types and decode functions of the timer compare unit.
// Assumes one peripheral clock domain and four compare channels.
package tcw_pkg;
   localparam int CNT_W = 16;
   localparam int NCH   = 4;
   localparam int PRE_W = 10;

   // Waveform mode field encodings
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_FRQ    = 3'h1;
   localparam logic [2:0] MODE_SS     = 3'h3;
   localparam logic [2:0] MODE_DSTOP  = 3'h5;
   localparam logic [2:0] MODE_DSBOTH = 3'h6;
   localparam logic [2:0] MODE_DSBOT  = 3'h7;

   // Clock source field: zero is off, top bit picks an event channel
   localparam logic [3:0] CLK_OFF    = 4'h0;
   localparam int         CLK_EV_BIT = 3;

   // Event action field
   localparam logic [2:0] EVACT_OFF     = 3'h0;
   localparam logic [2:0] EVACT_CAPT    = 3'h1;
   localparam logic [2:0] EVACT_FRQCAPT = 3'h5;
   localparam logic [2:0] EVACT_PWCAPT  = 3'h6;

   // Reset values and counter steps
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] PER_RST = 16'hFFFF;
   localparam logic [CNT_W-1:0] CC_RST  = 16'h0000;

   typedef struct packed {
      logic [3:0]     clock_source_field;
      logic [2:0]     waveform_mode_field;
      logic [2:0]     event_action;
      logic           lock_update;
      logic [NCH-1:0] channel_output_enable;
      logic [NCH-1:0] pin_invert_enable;
      logic [NCH-1:0] pin_dir_out;
   } tcw_cfg_t;

   typedef struct packed {
      logic [CNT_W-1:0] data;
      logic             dma;
      logic             cnt_wr;
      logic             per_wr;
      logic             period_buffer_wr;
      logic [NCH-1:0]   cc_wr;
      logic [NCH-1:0]   ccbuf_wr;
   } tcw_wr_t;

   typedef struct packed {
      logic update;
      logic restart;
      logic reset;
   } tcw_cmd_t;

   typedef struct packed {
      logic           ovf;
      logic           err;
      logic [NCH-1:0] cc;
   } tcw_evt_t;

   typedef struct packed {
      logic           overflow_flag;
      logic           capture_error_flag;
      logic [NCH-1:0] channel_match_flag;
   } tcw_flags_t;

   // Prescaler shift for clock select codes 1 to 7
   function automatic logic [3:0] div_shift(input logic [2:0] sel);
      case (sel)
         3'h2:    div_shift = 4'h1;
         3'h3:    div_shift = 4'h2;
         3'h4:    div_shift = 4'h3;
         3'h5:    div_shift = 4'h6;
         3'h6:    div_shift = 4'h8;
         3'h7:    div_shift = 4'hA;
         default: div_shift = 4'h0;
      endcase
   endfunction

   // Reserved encodings fall back to normal operation
   function automatic logic [2:0] eff_mode(input logic [2:0] m);
      case (m)
         MODE_FRQ, MODE_SS, MODE_DSTOP, MODE_DSBOTH, MODE_DSBOT: eff_mode = m;
         default: eff_mode = MODE_NORMAL;
      endcase
   endfunction

   function automatic logic is_dual(input logic [2:0] m);
      is_dual = (m == MODE_DSTOP) || (m == MODE_DSBOTH) || (m == MODE_DSBOT);
   endfunction

   function automatic logic is_capture(input logic [2:0] a);
      is_capture = (a == EVACT_CAPT) || (a == EVACT_FRQCAPT) || (a == EVACT_PWCAPT);
   endfunction
endpackage

// ### rtl/tcw_prescaler.sv
// Timer clock tick generator: prescaled peripheral clock or an event channel.
// Assumes event inputs are pulses from logic on the same clock.
`timescale 1ns/1ns
module tcw_prescaler #(
   parameter int PRE_W = tcw_pkg::PRE_W
) (
   input  logic       clock,
   input  logic       reset,
   input  logic       clk_en,
   input  logic       clear,
   input  logic [3:0] clock_source_field,
   input  logic [7:0] event_in,
   output logic       tick
);
   import tcw_pkg::*;
   logic [PRE_W-1:0] pre_r;
   logic [PRE_W-1:0] mask;

   // Free-running divider, realigned by restart so a new period starts clean
   always_ff @(posedge clock) begin
      if (reset || clear) begin
         pre_r <= '0;
      end else if (clk_en) begin
         pre_r <= pre_r + 1'b1;
      end
   end

   // One tick per 2^shift cycles when all masked bits are ones
   always_comb begin
      mask = PRE_W'((1 << div_shift(clock_source_field[2:0])) - 1);
      if (clock_source_field == CLK_OFF) begin
         tick = 1'b0;
      end else if (clock_source_field[CLK_EV_BIT]) begin
         tick = clk_en & event_in[clock_source_field[2:0]];
      end else begin
         tick = clk_en & ((pre_r & mask) == mask);
      end
   end
endmodule

// ### rtl/tcw_top.sv
// Compare channels, counter sequencing and waveform output of a 16-bit timer.
// Assumes all control inputs come from logic on the same clock; no register bus.
`timescale 1ns/1ns
module tcw_top (
   input  logic                      clock,
   input  logic                      reset,
   input  logic                      clk_en,
   input  tcw_pkg::tcw_cfg_t         cfg,
   input  tcw_pkg::tcw_wr_t          wr,
   input  tcw_pkg::tcw_cmd_t         cmd,
   input  logic                      forced_write,
   input  logic [tcw_pkg::NCH-1:0]   forced_output_level,
   input  tcw_pkg::tcw_evt_t         irq_enable,
   input  tcw_pkg::tcw_evt_t         flag_clear,
   input  logic                      capture_overflow,
   input  logic [7:0]                event_in,
   input  logic [tcw_pkg::NCH-1:0]   port_out_latch,
   output logic [tcw_pkg::CNT_W-1:0] count_value,
   output logic                      count_down,
   output logic [tcw_pkg::CNT_W-1:0] period_value,
   output logic [tcw_pkg::NCH-1:0][tcw_pkg::CNT_W-1:0] channel_compare_value,
   output logic [tcw_pkg::NCH-1:0]   waveform_output,
   output logic [tcw_pkg::NCH-1:0]   pin_out,
   output logic [tcw_pkg::NCH-1:0]   pin_oe,
   output tcw_pkg::tcw_flags_t       flags,
   output tcw_pkg::tcw_evt_t         irq,
   output tcw_pkg::tcw_evt_t         event_out,
   output logic                      dma_ovf_req,
   output logic [tcw_pkg::NCH-1:0]   dma_cc_req
);
   import tcw_pkg::*;

   // Counter and period state
   logic [CNT_W-1:0]            cnt_r;
   logic                        dir_r;
   logic [CNT_W-1:0]            per_r;
   logic [CNT_W-1:0]            period_buffer_r;
   logic                        period_buffer_vld_r;
   // Compare channel state
   logic [NCH-1:0][CNT_W-1:0]   cc_r;
   logic [NCH-1:0][CNT_W-1:0]   ccbuf_r;
   logic [NCH-1:0]              ccbuf_vld_r;
   logic [NCH-1:0]              dma_cc_r;
   logic [NCH-1:0]              wg;
   // Status, interrupt, event and pin state
   tcw_flags_t                  flags_r;
   tcw_flags_t                  flags_nxt;
   tcw_evt_t                    irq_r;
   tcw_evt_t                    evt_r;
   logic                        dma_ovf_r;
   logic [NCH-1:0]              pin_out_r;
   logic [NCH-1:0]              pin_oe_r;
   // Decoded controls
   logic [2:0]                  mode;
   logic                        off;
   logic                        ds;
   logic                        tick;
   logic                        srst;
   logic                        restart;
   logic [CNT_W-1:0]            top;
   logic                        at_top;
   logic                        at_bottom;
   logic                        ovf_evt;
   logic                        nat_upd;
   logic                        upd;
   logic                        capt;
   logic [NCH-1:0]              hit;
   logic [NCH-1:0]              wave_en;

   // Mode decode; reserved codes collapse onto normal
   assign mode = eff_mode(cfg.waveform_mode_field);
   assign ds   = is_dual(mode);
   assign off  = (cfg.clock_source_field == CLK_OFF);
   assign capt = is_capture(cfg.event_action);

   // Soft reset is honoured only with the clock source off
   assign srst    = reset | (clk_en & cmd.reset & off);
   assign restart = clk_en & cmd.restart;

   // Frequency mode takes its top from channel A
   assign top = (mode == MODE_FRQ) ? cc_r[0] : per_r;

   // Sequence points, all qualified by the timer tick
   assign at_top    = tick & ~dir_r & (cnt_r == top);
   assign at_bottom = ds ? (tick & dir_r & (cnt_r == CNT_RST)) : ((mode == MODE_SS) & at_top);

   // Overflow event position per mode
   always_comb begin
      case (mode)
         MODE_SS:     ovf_evt = at_bottom;
         MODE_DSTOP:  ovf_evt = at_top;
         MODE_DSBOTH: ovf_evt = at_top | at_bottom;
         MODE_DSBOT:  ovf_evt = at_bottom;
         default:     ovf_evt = at_top;
      endcase
   end

   // Natural update at top for normal and frequency, at bottom for PWM
   assign nat_upd = (ds || mode == MODE_SS) ? at_bottom : at_top;
   assign upd     = nat_upd | (clk_en & cmd.update & ~cfg.lock_update);

   // Timer clock source
   tcw_prescaler #(
      .PRE_W (PRE_W)
   ) u_pre (
      .clock              (clock),
      .reset              (srst),
      .clk_en             (clk_en),
      .clear              (restart),
      .clock_source_field (cfg.clock_source_field),
      .event_in           (event_in),
      .tick               (tick)
   );

   // Counter; a direct write beats counting, restart beats both
   always_ff @(posedge clock) begin
      if (srst || restart) begin
         cnt_r <= CNT_RST;
         dir_r <= 1'b0;
      end else if (clk_en) begin
         if (wr.cnt_wr) begin
            cnt_r <= wr.data;
         end else if (tick) begin
            if (!dir_r) begin
               if (cnt_r == top) begin
                  if (ds) begin
                     // Turn at top without repeating it: 2*period ticks
                     cnt_r <= cnt_r - CNT_ONE;
                     dir_r <= 1'b1;
                  end else begin
                     cnt_r <= CNT_RST;
                  end
               end else begin
                  // A top written below the count wraps through the maximum
                  cnt_r <= cnt_r + CNT_ONE;
               end
            end else if (cnt_r == CNT_RST) begin
               cnt_r <= CNT_ONE;
               dir_r <= 1'b0;
            end else begin
               cnt_r <= cnt_r - CNT_ONE;
            end
         end
      end
   end

   // Period and its buffer; buffered loads happen only on update
   always_ff @(posedge clock) begin
      if (srst) begin
         per_r        <= PER_RST;
         period_buffer_r     <= PER_RST;
         period_buffer_vld_r <= 1'b0;
      end else if (clk_en) begin
         if (wr.per_wr) begin
            per_r <= wr.data;
         end else if (upd && period_buffer_vld_r) begin
            per_r <= period_buffer_r;
         end
         if (wr.period_buffer_wr) begin
            period_buffer_r     <= wr.data;
            period_buffer_vld_r <= 1'b1;
         end else if (upd) begin
            period_buffer_vld_r <= 1'b0;
         end
      end
   end

   // Per-channel compare, buffer, DMA request and waveform
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign hit[i] = tick & (cnt_r == cc_r[i]);

      // Compare value loads from its buffer only at the update point
      always_ff @(posedge clock) begin
         if (srst) begin
            cc_r[i]        <= CC_RST;
            ccbuf_r[i]     <= CC_RST;
            ccbuf_vld_r[i] <= 1'b0;
         end else if (clk_en) begin
            if (wr.cc_wr[i]) begin
               cc_r[i] <= wr.data;
            end else if (upd && ccbuf_vld_r[i]) begin
               cc_r[i] <= ccbuf_r[i];
            end
            if (wr.ccbuf_wr[i]) begin
               ccbuf_r[i]     <= wr.data;
               ccbuf_vld_r[i] <= 1'b1;
            end else if (upd) begin
               ccbuf_vld_r[i] <= 1'b0;
            end
         end
      end

      // DMA request; a new match wins over the acknowledge
      always_ff @(posedge clock) begin
         if (srst) begin
            dma_cc_r[i] <= 1'b0;
         end else if (clk_en) begin
            if (hit[i]) begin
               dma_cc_r[i] <= 1'b1;
            end else if (wr.dma && (capt ? wr.cc_wr[i] : wr.ccbuf_wr[i])) begin
               dma_cc_r[i] <= 1'b0;
            end
         end
      end

      tcw_wave u_wave (
         .clock     (clock),
         .reset     (srst),
         .clk_en    (clk_en),
         .clear     (restart),
         .mode      (mode),
         .off       (off),
         .hit       ((i == 0 || mode != MODE_FRQ) ? hit[i] : 1'b0),
         .dir_down  (dir_r),
         .at_top    (at_top),
         .at_bottom (at_bottom),
         .force_wr  (forced_write),
         .force_lvl (forced_output_level[i]),
         .wg_r      (wg[i])
      );

      // Override only with a waveform mode, no event action and enable set
      assign wave_en[i] = (mode != MODE_NORMAL) & (cfg.event_action == EVACT_OFF)
                          & cfg.channel_output_enable[i];
   end

   // Sticky flags: a set in the same cycle as a clear wins
   always_comb begin
      flags_nxt.overflow_flag = ovf_evt
         | (flags_r.overflow_flag & ~flag_clear.ovf);
      flags_nxt.capture_error_flag = (clk_en & capture_overflow)
         | (flags_r.capture_error_flag & ~flag_clear.err);
      flags_nxt.channel_match_flag = hit
         | (flags_r.channel_match_flag & ~flag_clear.cc);
   end

   // Flags land on the edge after the tick that saw the match
   always_ff @(posedge clock) begin
      if (srst) begin
         flags_r <= '0;
      end else if (clk_en) begin
         flags_r <= flags_nxt;
      end
   end

   // Interrupt lines follow the flags through their enables
   always_ff @(posedge clock) begin
      if (srst) begin
         irq_r <= '0;
      end else if (clk_en) begin
         irq_r.ovf <= flags_nxt.overflow_flag & irq_enable.ovf;
         irq_r.err <= flags_nxt.capture_error_flag & irq_enable.err;
         irq_r.cc  <= flags_nxt.channel_match_flag & irq_enable.cc;
      end
   end

   // One event pulse per flag-setting condition
   always_ff @(posedge clock) begin
      if (srst) begin
         evt_r <= '0;
      end else if (clk_en) begin
         evt_r.ovf <= ovf_evt;
         evt_r.err <= capture_overflow;
         evt_r.cc  <= hit;
      end
   end

   // Overflow DMA request; the error flag has no DMA path
   always_ff @(posedge clock) begin
      if (srst) begin
         dma_ovf_r <= 1'b0;
      end else if (clk_en) begin
         if (ovf_evt) begin
            dma_ovf_r <= 1'b1;
         end else if (wr.dma && (wr.cnt_wr || wr.per_wr || wr.period_buffer_wr)) begin
            dma_ovf_r <= 1'b0;
         end
      end
   end

   // Pin stage: one flop of latency, inversion applies to either source
   always_ff @(posedge clock) begin
      if (srst) begin
         pin_out_r <= '0;
         pin_oe_r  <= '0;
      end else if (clk_en) begin
         for (int i = 0; i < NCH; i++) begin
            pin_out_r[i] <= (wave_en[i] ? wg[i] : port_out_latch[i])
                            ^ cfg.pin_invert_enable[i];
         end
         pin_oe_r <= cfg.pin_dir_out;
      end
   end

   // Outputs straight from flops
   assign count_value           = cnt_r;
   assign count_down            = dir_r;
   assign period_value          = per_r;
   assign channel_compare_value = cc_r;
   assign waveform_output       = wg;
   assign pin_out               = pin_out_r;
   assign pin_oe                = pin_oe_r;
   assign flags                 = flags_r;
   assign irq                   = irq_r;
   assign event_out             = evt_r;
   assign dma_ovf_req           = dma_ovf_r;
   assign dma_cc_req            = dma_cc_r;
endmodule

// ### rtl/tcw_wave.sv
// Waveform generator of one compare channel.
// Assumes hit, at_top and at_bottom are already qualified by the timer tick.
`timescale 1ns/1ns
module tcw_wave (
   input  logic       clock,
   input  logic       reset,
   input  logic       clk_en,
   input  logic       clear,
   input  logic [2:0] mode,
   input  logic       off,
   input  logic       hit,
   input  logic       dir_down,
   input  logic       at_top,
   input  logic       at_bottom,
   input  logic       force_wr,
   input  logic       force_lvl,
   output logic       wg_r
);
   import tcw_pkg::*;

   // Output level per mode; reset covers soft reset, clear covers restart
   always_ff @(posedge clock) begin
      if (reset || clear) begin
         wg_r <= 1'b0;
      end else if (clk_en) begin
         if (off) begin
            if (force_wr) begin
               wg_r <= force_lvl;
            end
         end else begin
            case (mode)
               MODE_FRQ: begin
                  if (hit) begin
                     wg_r <= ~wg_r;
                  end
               end
               MODE_SS: begin
                  // Match wins over top so a full-scale compare still sets
                  if (hit) begin
                     wg_r <= 1'b1;
                  end else if (at_top) begin
                     wg_r <= 1'b0;
                  end
               end
               MODE_DSTOP, MODE_DSBOTH, MODE_DSBOT: begin
                  if (hit) begin
                     wg_r <= dir_down;
                  end else if (at_bottom) begin
                     wg_r <= 1'b1;
                  end
               end
               default: begin
                  wg_r <= wg_r;
               end
            endcase
         end
      end
   end
endmodule

// ### test/tb_top.sv
// Bench of the timer compare unit: pin override, periods, flags, DMA and commands.
// Assumes the unit, the pad model and the bound checker are compiled with it.
`timescale 1ns/1ns
module tb_top;
   import tcw_pkg::*;
   logic                      clock = 1'b0;
   logic                      reset = 1'b1;
   tcw_cfg_t                  cfg = '0;
   tcw_wr_t                   wr = '0;
   tcw_cmd_t                  cmd = '0;
   tcw_evt_t                  irq_en = '0, fclr = '0, irq, ev;
   tcw_flags_t                flags;
   logic                      fwr = 1'b0, cap_ovf = 1'b0, ev_on = 1'b0, count_down, dma_ovf_req;
   logic [NCH-1:0]            flvl = '0, latch = '0, wave, pin_out, pin_oe, dma_cc_req, pad;
   logic [7:0]                event_in = '0;
   logic [2:0]                ev_n = '0;
   logic [1:0]                ev_ph = '0;
   logic [CNT_W-1:0]          count_value, period_value;
   logic [NCH-1:0][CNT_W-1:0] ccv;
   logic [15:0]               notes[$];
   int                        errors = 0, checks_done = 0, gap = 0, cyc = 0;

   always #10 clock = ~clock;

   tcw_top uut (.clock(clock), .reset(reset), .clk_en(1'b1), .cfg(cfg), .wr(wr), .cmd(cmd),
      .forced_write(fwr), .forced_output_level(flvl), .irq_enable(irq_en), .flag_clear(fclr),
      .capture_overflow(cap_ovf), .event_in(event_in), .port_out_latch(latch),
      .count_value(count_value), .count_down(count_down), .period_value(period_value),
      .channel_compare_value(ccv), .waveform_output(wave), .pin_out(pin_out),
      .pin_oe(pin_oe), .flags(flags), .irq(irq), .event_out(ev), .dma_ovf_req(dma_ovf_req),
      .dma_cc_req(dma_cc_req));
   tcw_pin_load u_load (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

   task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
      checks_done++;
      if (got !== ex) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Event pulses every third cycle, a hang ceiling, and the match-gap scoreboard
   always @(posedge clock) begin
      ev_ph <= (ev_ph == 2'h2) ? 2'h0 : ev_ph + 2'h1;
      event_in <= (ev_on && ev_ph == 2'h0) ? 8'h01 << ev_n : 8'h00;
      gap <= gap + 1;
      if (ev.cc[0] === 1'b1) begin
         gap <= 1;
         if (notes.size() > 0)
            chk("match gap", notes.pop_front(), gap[15:0]);
      end
      cyc++;
      if (cyc == 60000) begin
         errors++;
         give_verdict();
      end
   end

   task automatic put(tcw_wr_t w);
      @(posedge clock);
      wr <= w;
      @(posedge clock);
      wr <= '0;
   endtask

   task automatic pulse(tcw_cmd_t c);
      @(posedge clock);
      cmd <= c;
      @(posedge clock);
      cmd <= '0;
      @(negedge clock);
   endtask

   // Program period and compare with the clock off, restart, then time two matches
   task automatic run(logic [2:0] m, logic [3:0] c, logic [15:0] p, logic [15:0] v, int ex);
      @(posedge clock);
      cfg.clock_source_field <= CLK_OFF;
      cfg.waveform_mode_field <= m;
      cfg.event_action <= EVACT_OFF;
      cmd.restart <= 1'b1;
      wr <= '{data: p, per_wr: 1'b1, default: '0};
      @(posedge clock);
      cmd.restart <= 1'b0;
      wr <= '{data: v, cc_wr: 4'h1, default: '0};
      @(posedge clock);
      wr <= '0;
      cfg.clock_source_field <= c;
      repeat (2) @(negedge clock iff ev.cc[0] === 1'b1);
      repeat (2) notes.push_back(ex[15:0]);
      repeat (2) @(negedge clock iff ev.cc[0] === 1'b1);
   endtask

   initial begin
      logic [31:0] r;
      logic [3:0]  ovm, pe;
      int          sh[8];
      sh = '{0, 0, 1, 2, 3, 6, 8, 10};
      r = $urandom(98575);
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      chk("period", PER_RST, period_value);
      // Clock off: forced levels, then every mode against random pin settings
      for (int m = 0; m < 8; m++) begin
         r = $urandom;
         @(posedge clock);
         cfg.waveform_mode_field <= m[2:0];
         cfg.event_action <= {2'b00, r[16]};
         cfg.channel_output_enable <= r[3:0];
         cfg.pin_invert_enable <= r[7:4];
         cfg.pin_dir_out <= r[11:8];
         latch <= r[15:12];
         flvl <= r[20:17];
         fwr <= 1'b1;
         @(posedge clock);
         fwr <= 1'b0;
         @(posedge clock);
         @(negedge clock);
         ovm = (m inside {1, 3, 5, 6, 7} && !r[16]) ? r[3:0] : 4'h0;
         pe = ((r[20:17] & ovm) | (r[15:12] & ~ovm)) ^ r[7:4];
         chk("wave", 16'(r[20:17]), 16'(wave));
         chk("pin", 16'(pe), 16'(pin_out));
         chk("pad", 16'(pe & r[11:8]), 16'(pad));
      end
      for (int m = 0; m < 8; m++)
         run(m[2:0], 4'h1, 16'h0006, 16'h0003, m == 1 ? 4 : (m >= 5 ? 6 : 7));
      for (int c = 1; c < 8; c++)
         run(MODE_SS, c[3:0], 16'h0003, 16'h0001, 4 << sh[c]);
      ev_n = 3'($urandom);
      @(posedge clock);
      ev_on <= 1'b1;
      irq_en <= '{ovf: 1'b1, err: 1'b0, cc: 4'h1};
      run(MODE_SS, {1'b1, ev_n}, 16'h0003, 16'h0001, 12);
      chk("flags", 16'h002F, 16'(flags));
      chk("irq", 16'h0021, 16'(irq));
      chk("dma", 16'h001F, 16'({dma_ovf_req, dma_cc_req}));
      pulse('{reset: 1'b1, default: '0});
      chk("period", 16'h0003, period_value);
      @(posedge clock);
      cfg.clock_source_field <= CLK_OFF;
      ev_on <= 1'b0;
      put('{data: 16'h0003, dma: 1'b1, per_wr: 1'b1, ccbuf_wr: 4'hF, default: '0});
      @(negedge clock);
      chk("dma", 16'h0000, 16'({dma_ovf_req, dma_cc_req}));
      // Clearing and setting the error flag together: the set must win
      @(posedge clock);
      fclr <= '1;
      cap_ovf <= 1'b1;
      @(posedge clock);
      fclr <= '0;
      cap_ovf <= 1'b0;
      @(negedge clock);
      chk("flags", 16'h0010, 16'(flags));
      chk("events", 16'h0010, 16'(ev));
      chk("irq", 16'h0000, 16'(irq));
      pulse('{reset: 1'b1, default: '0});
      chk("period", PER_RST, period_value);
      chk("flags", 16'h0000, 16'(flags));
      put('{data: 16'h0005, ccbuf_wr: 4'h1, default: '0});
      cfg.lock_update <= 1'b1;
      pulse('{update: 1'b1, default: '0});
      chk("compare", CC_RST, ccv[0]);
      @(posedge clock);
      cfg.lock_update <= 1'b0;
      pulse('{update: 1'b1, default: '0});
      chk("compare", 16'h0005, ccv[0]);
      // Buffered compare must wait for the wrap before it loads
      run(MODE_SS, 4'h1, 16'h0007, 16'h0002, 8);
      @(negedge clock iff count_value === 16'h0003);
      put('{data: 16'h0006, ccbuf_wr: 4'h1, default: '0});
      @(negedge clock);
      chk("compare", 16'h0002, ccv[0]);
      @(negedge clock iff count_value === 16'h0002);
      chk("compare", 16'h0006, ccv[0]);
      give_verdict();
   end
endmodule

// ### test/tcw_monitor.sv
// Checker of the timer compare unit, watching only the ports of its top module.
// Assumes one clock domain; bound to every tcw_top at the foot of this file.
`timescale 1ns/1ns
module tcw_monitor (
   input logic                                         clock,
   input logic                                         reset,
   input logic                                         clk_en,
   input tcw_pkg::tcw_cfg_t                            cfg,
   input tcw_pkg::tcw_wr_t                             wr,
   input tcw_pkg::tcw_cmd_t                            cmd,
   input logic [tcw_pkg::NCH-1:0]                      port_out_latch,
   input logic [tcw_pkg::CNT_W-1:0]                    count_value,
   input logic                                         count_down,
   input logic [tcw_pkg::CNT_W-1:0]                    period_value,
   input logic [tcw_pkg::NCH-1:0][tcw_pkg::CNT_W-1:0]  channel_compare_value,
   input logic [tcw_pkg::NCH-1:0]                      waveform_output,
   input logic [tcw_pkg::NCH-1:0]                      pin_out,
   input logic [tcw_pkg::NCH-1:0]                      pin_oe,
   input tcw_pkg::tcw_flags_t                          flags,
   input tcw_pkg::tcw_evt_t                            irq,
   input tcw_pkg::tcw_evt_t                            event_out,
   input logic                                         dma_ovf_req
);
   import tcw_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   logic run1, ovr, hold;
   // Divide-by-one ticks every enabled cycle
   assign run1 = clk_en && cfg.clock_source_field == 4'h1 && !cmd.restart && !wr.cnt_wr
      && cfg.event_action == EVACT_OFF;
   assign ovr = cfg.event_action == EVACT_OFF && cfg.channel_output_enable[0]
      && !(cfg.waveform_mode_field inside {3'h0, 3'h2, 3'h4});
   // A soft reset command with the clock source off rewrites the pin flops, so skip reset and restart cycles
   assign hold = clk_en && !cmd.restart && !cmd.reset;
   sequence s_hit;
      run1 && count_value == channel_compare_value[0];
   endsequence
   sequence s_top(logic m);
      run1 && count_value == period_value && m;
   endsequence
   a_match_flag: assert property (s_hit |=> flags.channel_match_flag[0] && event_out.cc[0])
      else $error("match without flag or event");
   a_flag_event: assert property ($rose(flags.overflow_flag) |-> event_out.ovf)
      else $error("overflow flag without event");
   a_irq_flag: assert property (irq.cc[0] |-> flags.channel_match_flag[0])
      else $error("channel interrupt without flag");
   a_pin_level: assert property (hold |=> pin_out[0] ==
      (($past(ovr) ? $past(waveform_output[0]) : $past(port_out_latch[0]))
      ^ $past(cfg.pin_invert_enable[0])))
      else $error("pin level wrong");
   a_pin_dir: assert property (hold |=> pin_oe == $past(cfg.pin_dir_out))
      else $error("pin direction not followed");
   a_restart: assert property (clk_en && cmd.restart |=>
      count_value == CNT_RST && !count_down && waveform_output == 4'h0)
      else $error("restart left state");
   a_ss_wrap: assert property (s_top(cfg.waveform_mode_field == MODE_SS) |=>
      count_value == CNT_RST)
      else $error("single slope did not wrap");
   a_ds_turn: assert property (s_top(cfg.waveform_mode_field inside {3'h5, 3'h6, 3'h7}
      && period_value != CNT_RST) |=> count_value == $past(period_value) - CNT_ONE)
      else $error("dual slope did not turn");
   a_frq_toggle: assert property (s_hit ##0 cfg.waveform_mode_field == MODE_FRQ |=>
      waveform_output[0] != $past(waveform_output[0]))
      else $error("frequency output did not toggle");
   a_lock_hold: assert property (clk_en && cmd.update && cfg.lock_update && !wr.cc_wr[0]
      && !cmd.reset && cfg.clock_source_field == CLK_OFF |=> $stable(channel_compare_value[0]))
      else $error("locked update changed compare");
   a_dma_ack: assert property (clk_en && wr.dma && wr.per_wr
      && cfg.clock_source_field == CLK_OFF |=> !dma_ovf_req)
      else $error("overflow request not acknowledged");
endmodule

bind tcw_top tcw_monitor u_mon (.*);

// ### test/tcw_pin_load.sv
// Pad model: each timer pin drives an external load held by a weak pull-down.
// Assumes pin_oe is high while the timer drives the pad.
`timescale 1ns/1ns
module tcw_pin_load (
   input  logic [tcw_pkg::NCH-1:0] pin_out,
   input  logic [tcw_pkg::NCH-1:0] pin_oe,
   output logic [tcw_pkg::NCH-1:0] pad
);
   import tcw_pkg::*;
   // A released pad falls to the pull-down, never keeps the last level
   assign pad = pin_out & pin_oe;
endmodule
